// file: hw/rsel_pkg.sv
// package: register map, field layout, modes and helpers of the selector
package rsel_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] RSEL_OFS_PRIO   = 8'h14;
	localparam logic [7:0] RSEL_OFS_MODE   = 8'h15;
	localparam logic [7:0] RSEL_OFS_HOLD   = 8'h16;
	localparam logic [7:0] RSEL_OFS_SETUP  = 8'h17;
	localparam logic [7:0] RSEL_OFS_STATUS = 8'h18;

	// ------------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------------
	localparam logic [7:0] RSEL_RST_PRIO  = 8'he4;
	localparam logic [7:0] RSEL_RST_MODE  = 8'h00;
	localparam logic [7:0] RSEL_RST_HOLD  = 8'h80;
	localparam logic [7:0] RSEL_RST_SETUP = 8'h82;

	// ------------------------------------------------------------------
	// field positions and writable masks
	// ------------------------------------------------------------------
	localparam int RSEL_MODE_SEL_LSB   = 0;
	localparam int RSEL_MODE_MA_LSB    = 2;
	localparam int RSEL_MODE_REVERT_BIT = 4;
	localparam int RSEL_MODE_DIV4_BIT  = 5;
	localparam int RSEL_MODE_BLOCK_BIT = 6;
	localparam int RSEL_SETUP_REVAL_LSB = 0;
	localparam int RSEL_SETUP_PD_LSB   = 2;
	localparam int RSEL_SETUP_RATE_LSB = 6;
	localparam int RSEL_STAT_REF_LSB   = 0;
	localparam int RSEL_STAT_HOLD_BIT  = 2;
	localparam int RSEL_STAT_VALID_LSB = 4;
	localparam logic [7:0] RSEL_MODE_WMASK  = 8'h7f;
	localparam logic [7:0] RSEL_SETUP_WMASK = 8'hcf;

	// ------------------------------------------------------------------
	// re-validation counts
	// ------------------------------------------------------------------
	localparam logic [8:0] RSEL_REVAL_C0      = 9'h002;
	localparam logic [8:0] RSEL_REVAL_C1      = 9'h010;
	localparam logic [8:0] RSEL_REVAL_C2      = 9'h020;
	localparam logic [8:0] RSEL_REVAL_C3      = 9'h040;
	localparam logic [8:0] RSEL_REVAL_RST_CNT = 9'h020;
	localparam logic [1:0] RSEL_PRESCALE_LAST = 2'h3;

	// ------------------------------------------------------------------
	// modes and states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		RSEL_MODE_MANUAL    = 2'h0,
		RSEL_MODE_AUTO      = 2'h1,
		RSEL_MODE_SHOLD     = 2'h2,
		RSEL_MODE_AUTO_HOLD = 2'h3
	} rsel_mode_type;

	typedef enum logic [1:0] {
		RSEL_ST_MANUAL   = 2'h0,
		RSEL_ST_TRACK    = 2'h1,
		RSEL_ST_HOLDOVER = 2'h3,
		RSEL_ST_HOLDOFF  = 2'h2
	} rsel_state_type;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// counted units only; the prescaler alone makes a unit four periods
	function automatic logic [8:0] rsel_reval_load(input logic [1:0] code);
		logic [8:0] base;
		unique case (code)
			2'h0: base = RSEL_REVAL_C0;
			2'h1: base = RSEL_REVAL_C1;
			2'h2: base = RSEL_REVAL_C2;
			2'h3: base = RSEL_REVAL_C3;
		endcase
		return base;
	endfunction

	// rank key: priority on top, lower index wins a tie
	function automatic logic [3:0] rsel_rank(input logic [7:0] prio,
	                                         input logic [1:0] idx);
		logic [1:0] p;
		unique case (idx)
			2'h0: p = prio[7:6];
			2'h1: p = prio[5:4];
			2'h2: p = prio[3:2];
			2'h3: p = prio[1:0];
		endcase
		return {p, ~idx};
	endfunction

	// returns {found, index} of the best valid input
	function automatic logic [2:0] rsel_best(input logic [3:0] valid,
	                                         input logic [7:0] prio);
		logic       found;
		logic [1:0] bi;
		found = 1'b0;
		bi    = 2'h0;
		for (int i = 0; i < 4; i++) begin
			if (valid[i] && (!found ||
			    rsel_rank(prio, 2'(i)) > rsel_rank(prio, bi))) begin
				found = 1'b1;
				bi    = 2'(i);
			end
		end
		return {found, bi};
	endfunction

endpackage

// file: hw/rsel_reval.sv
// module: per-input re-validation counter with optional divide-by-four
`timescale 1ns/1ps
`default_nettype none
module rsel_reval
	import rsel_pkg::*;
(
	input  wire logic   core_clk_in,
	input  wire logic   reset_n_in,
	rsel_reval_if.mon   chk_if
);

	typedef struct packed {
		logic [8:0] cnt;
		logic [1:0] pre;
		logic       valid;
	} rsel_rv_state_type;

	localparam rsel_rv_state_type RV_RST = '{
		cnt: RSEL_REVAL_RST_CNT, pre: 2'h0, valid: 1'b0};

	rsel_rv_state_type st_r;
	rsel_rv_state_type st_nxt;
	logic [8:0]        load;

	// ------------------------------------------------------------------
	// counting
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		load   = rsel_reval_load(chk_if.count_code);
		if (chk_if.los_event) begin
			st_nxt.valid = 1'b0;
			st_nxt.cnt   = load;
			st_nxt.pre   = 2'h0;
		end else if (!st_r.valid) begin
			if (chk_if.period_miss) begin
				st_nxt.cnt = load;
				st_nxt.pre = 2'h0;
			end else if (chk_if.period_edge) begin
				// only every fourth period counts when prescaled
				if (chk_if.prescale && st_r.pre != RSEL_PRESCALE_LAST) begin
					st_nxt.pre = st_r.pre + 2'h1;
				end else begin
					st_nxt.pre = 2'h0;
					if (st_r.cnt <= 9'h001) begin
						st_nxt.cnt   = 9'h000;
						st_nxt.valid = 1'b1;
					end else begin
						st_nxt.cnt = st_r.cnt - 9'h001;
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r <= RV_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign chk_if.valid = st_r.valid;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	AST_RV_LOAD: assert property (
		chk_if.los_event |=> !st_r.valid && st_r.cnt == $past(load))
		else $error("re-validation count not loaded on loss");

	AST_RV_VALID_CAUSE: assert property (
		$rose(st_r.valid) |-> $past(chk_if.period_edge) &&
		    $past(st_r.cnt) <= 9'h001)
		else $error("input valid without exhausted count");

	AST_RV_PRESCALE: assert property (
		(chk_if.prescale && !st_r.valid && chk_if.period_edge &&
		 !chk_if.los_event && !chk_if.period_miss &&
		 st_r.pre != RSEL_PRESCALE_LAST) |=> $stable(st_r.cnt))
		else $error("prescaled count moved before fourth period");

	AST_RV_DIRECT: assert property (
		(!chk_if.prescale && !st_r.valid && chk_if.period_edge &&
		 !chk_if.los_event && !chk_if.period_miss && st_r.cnt > 9'h001)
		|=> st_r.cnt == $past(st_r.cnt) - 9'h001)
		else $error("direct count did not step per period");

endmodule
`default_nettype wire

// file: hw/rsel_reval_if.sv
// interface: one input's link between selector and re-validation counter
`timescale 1ns/1ps
`default_nettype none
interface rsel_reval_if;
	logic       period_edge;
	logic       period_miss;
	logic       los_event;
	logic       prescale;
	logic [1:0] count_code;
	logic       valid;

	modport ctl (
		output period_edge,
		output period_miss,
		output los_event,
		output prescale,
		output count_code,
		input  valid
	);

	modport mon (
		input  period_edge,
		input  period_miss,
		input  los_event,
		input  prescale,
		input  count_code,
		output valid
	);
endinterface
`default_nettype wire

// file: hw/rsel_top.sv
// module: reference input selector with registers, modes and failover
`timescale 1ns/1ps
`default_nettype none
module rsel_top
	import rsel_pkg::*;
#(
	parameter int NUM_INPUTS        = 4,
	parameter int HOLDOFF_DIV_LOG2  = 15
)
(
	input  wire logic       core_clk_in,
	input  wire logic       reset_n_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	output var  logic [7:0] reg_rdata_out,
	input  wire logic [3:0] in_period_edge_in,
	input  wire logic [3:0] in_period_miss_in,
	input  wire logic [3:0] signal_loss_in,
	input  wire logic       vcxo_tick_in,
	output var  logic [1:0] ref_select_out,
	output var  logic       holdover_out,
	output var  logic [3:0] input_valid_out,
	output var  logic       reference_loss_block_out,
	output var  logic [1:0] input_power_down_out
);

	localparam int RATE_W = HOLDOFF_DIV_LOG2 + 3;

	// ------------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------------
	if (NUM_INPUTS != 4 || HOLDOFF_DIV_LOG2 < 1 ||
	    HOLDOFF_DIV_LOG2 > 24) begin : g_bad_param
		$error("rsel_top: unsupported parameter value");
	end

	typedef struct packed {
		logic [7:0]     prio_r;
		logic [7:0]     mode_r;
		logic [7:0]     hold_set_r;
		logic [7:0]     setup_r;
		rsel_state_type state;
		logic [1:0]     ref_r;
		logic           override;
		logic           hold_run;
		logic [7:0]     hold_cnt;
		logic [RATE_W-1:0] rate_cnt;
		logic [3:0]     valid_prev;
		logic           hold_flag;
		logic [7:0]     rdata;
	} rsel_top_state_type;

	localparam rsel_top_state_type TOP_RST = '{
		prio_r:     RSEL_RST_PRIO,
		mode_r:     RSEL_RST_MODE,
		hold_set_r: RSEL_RST_HOLD,
		setup_r:    RSEL_RST_SETUP,
		state:      RSEL_ST_MANUAL,
		hold_cnt:   RSEL_RST_HOLD,
		default:    '0};

	rsel_top_state_type st_r;
	rsel_top_state_type st_nxt;
	logic [3:0]         valid_w;
	rsel_mode_type      mode;
	logic [1:0]         sel;
	logic               revert_en;
	logic [2:0]         best;
	logic               cur_ok;
	logic               hold_tick;
	logic [RATE_W-1:0]  rate_limit;
	logic [3:0]         revalid;

	// ------------------------------------------------------------------
	// re-validation counters
	// ------------------------------------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_in
		rsel_reval_if rv_if ();
		assign rv_if.period_edge = in_period_edge_in[g];
		assign rv_if.period_miss = in_period_miss_in[g];
		assign rv_if.los_event   = signal_loss_in[g];
		assign rv_if.prescale    = st_r.mode_r[RSEL_MODE_DIV4_BIT];
		assign rv_if.count_code  =
			st_r.setup_r[RSEL_SETUP_REVAL_LSB +: 2];
		assign valid_w[g]        = rv_if.valid;
		rsel_reval u_reval (
			.core_clk_in (core_clk_in),
			.reset_n_in  (reset_n_in),
			.chk_if      (rv_if.mon)
		);
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		mode   = rsel_mode_type'(st_r.mode_r[RSEL_MODE_MA_LSB +: 2]);
		sel    = st_r.mode_r[RSEL_MODE_SEL_LSB +: 2];
		revert_en = st_r.mode_r[RSEL_MODE_REVERT_BIT];
		best   = rsel_best(valid_w, st_r.prio_r);
		cur_ok = valid_w[st_r.ref_r];
		// rising valid of inputs other than the reference
		revalid = valid_w & ~st_r.valid_prev & ~(4'h1 << st_r.ref_r);
		// holdoff rate: one tick per 2^(base+rate) vcxo pulses
		rate_limit = {RATE_W{1'b1}} >>
			(2'h3 - st_r.setup_r[RSEL_SETUP_RATE_LSB +: 2]);
		hold_tick  = vcxo_tick_in && st_r.rate_cnt == rate_limit;
		st_nxt.valid_prev = valid_w;
		if (vcxo_tick_in) begin
			st_nxt.rate_cnt = hold_tick ? '0 : st_r.rate_cnt + 1'b1;
		end

		// register writes
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				RSEL_OFS_PRIO:  st_nxt.prio_r = reg_wdata_in;
				RSEL_OFS_MODE: begin
					st_nxt.mode_r   = reg_wdata_in & RSEL_MODE_WMASK;
					// a fresh select write takes back a failover
					st_nxt.override = 1'b0;
				end
				RSEL_OFS_HOLD:  st_nxt.hold_set_r = reg_wdata_in;
				RSEL_OFS_SETUP: st_nxt.setup_r =
					reg_wdata_in & RSEL_SETUP_WMASK;
				default: ;
			endcase
		end

		// reads answer one cycle later, unmapped reads give zero
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				RSEL_OFS_PRIO:   st_nxt.rdata = st_r.prio_r;
				RSEL_OFS_MODE:   st_nxt.rdata = st_r.mode_r;
				RSEL_OFS_HOLD:   st_nxt.rdata = st_r.hold_set_r;
				RSEL_OFS_SETUP:  st_nxt.rdata = st_r.setup_r;
				RSEL_OFS_STATUS: begin
					st_nxt.rdata = 8'h00;
					st_nxt.rdata[RSEL_STAT_REF_LSB +: 2] = st_r.ref_r;
					st_nxt.rdata[RSEL_STAT_HOLD_BIT]     = st_r.hold_flag;
					st_nxt.rdata[RSEL_STAT_VALID_LSB +: 4] = valid_w;
				end
				default: st_nxt.rdata = 8'h00;
			endcase
		end

		// selection state machine
		unique case (st_r.state)
			RSEL_ST_MANUAL: begin
				st_nxt.ref_r    = sel;
				st_nxt.override = 1'b0;
				if (mode == RSEL_MODE_SHOLD) begin
					st_nxt.state = RSEL_ST_HOLDOFF;
				end else if (mode != RSEL_MODE_MANUAL) begin
					st_nxt.state = RSEL_ST_TRACK;
				end
			end
			RSEL_ST_HOLDOFF: begin
				if (mode != RSEL_MODE_SHOLD) begin
					st_nxt.hold_run = 1'b0;
					st_nxt.state    = mode[0] ? RSEL_ST_TRACK :
						RSEL_ST_MANUAL;
				end else begin
					if (!st_r.override) begin
						st_nxt.ref_r = sel;
					end
					if (!st_r.hold_run && !cur_ok) begin
						st_nxt.hold_run = 1'b1;
						st_nxt.hold_cnt = st_r.hold_set_r;
					end else if (st_r.hold_run && cur_ok) begin
						// reference came back before expiry
						st_nxt.hold_run = 1'b0;
					end else if (st_r.hold_run && hold_tick) begin
						if (st_r.hold_cnt <= 8'h01) begin
							st_nxt.hold_cnt = st_r.hold_set_r;
							if (best[2]) begin
								st_nxt.ref_r    = best[1:0];
								st_nxt.override = 1'b1;
							end
						end else begin
							st_nxt.hold_cnt = st_r.hold_cnt - 8'h01;
						end
					end
				end
			end
			RSEL_ST_TRACK: begin
				if (!mode[0]) begin
					st_nxt.state = (mode == RSEL_MODE_SHOLD) ?
						RSEL_ST_HOLDOFF : RSEL_ST_MANUAL;
				end else if (!cur_ok) begin
					if (best[2]) begin
						st_nxt.ref_r = best[1:0];
					end else if (mode == RSEL_MODE_AUTO_HOLD) begin
						st_nxt.state = RSEL_ST_HOLDOVER;
					end
				end else if (revert_en && |revalid && best[2] &&
				    rsel_rank(st_r.prio_r, best[1:0]) >
				    rsel_rank(st_r.prio_r, st_r.ref_r)) begin
					st_nxt.ref_r = best[1:0];
				end
			end
			RSEL_ST_HOLDOVER: begin
				if (!mode[0]) begin
					st_nxt.state = (mode == RSEL_MODE_SHOLD) ?
						RSEL_ST_HOLDOFF : RSEL_ST_MANUAL;
				end else if (best[2]) begin
					st_nxt.ref_r = best[1:0];
					st_nxt.state = RSEL_ST_TRACK;
				end else if (mode == RSEL_MODE_AUTO) begin
					st_nxt.state = RSEL_ST_TRACK;
				end
			end
		endcase
		st_nxt.hold_flag = (st_nxt.state == RSEL_ST_HOLDOVER) ||
			(st_nxt.state == RSEL_ST_HOLDOFF && st_nxt.hold_run);
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r <= TOP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign reg_rdata_out            = st_r.rdata;
	assign ref_select_out           = st_r.ref_r;
	assign holdover_out             = st_r.hold_flag;
	assign input_valid_out          = valid_w;
	assign reference_loss_block_out = st_r.mode_r[RSEL_MODE_BLOCK_BIT];
	assign input_power_down_out     = st_r.setup_r[RSEL_SETUP_PD_LSB +: 2];

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_holdoff_expire;
		st_r.state == RSEL_ST_HOLDOFF && mode == RSEL_MODE_SHOLD &&
		st_r.hold_run && !cur_ok && hold_tick &&
		st_r.hold_cnt <= 8'h01 && best[2] && !reg_wr_in;
	endsequence

	sequence s_track_ok_stable;
		st_r.state == RSEL_ST_TRACK && mode[0] && cur_ok && !reg_wr_in;
	endsequence

	AST_MANUAL_SEL: assert property (
		st_r.state == RSEL_ST_MANUAL |=>
		    st_r.ref_r == $past(st_r.mode_r[1:0]))
		else $error("manual reference differs from select field");

	AST_NONREV_HOLD: assert property (
		(s_track_ok_stable and !revert_en) |=> $stable(st_r.ref_r))
		else $error("reference moved without revertive switching");

	AST_REV_UPRANK: assert property (
		s_track_ok_stable ##1 st_r.ref_r != $past(st_r.ref_r) |->
		    rsel_rank(st_r.prio_r, st_r.ref_r) >
		    rsel_rank(st_r.prio_r, $past(st_r.ref_r)))
		else $error("revertive switch to a lower ranked input");

	AST_FAILOVER_BEST: assert property (
		(st_r.state == RSEL_ST_TRACK && mode[0] && !cur_ok && best[2])
		|=> st_r.ref_r == $past(best[1:0]))
		else $error("auto failover missed the best valid input");

	AST_HOLDOFF_EXPIRE: assert property (
		s_holdoff_expire |=> st_r.override &&
		    st_r.hold_cnt == $past(st_r.hold_set_r) &&
		    st_r.ref_r == $past(best[1:0]))
		else $error("holdoff expiry did not fail over and reload");

	AST_TIE_INDEX: assert property (
		(valid_w[0] && valid_w[1] &&
		 st_r.prio_r[7:6] == st_r.prio_r[5:4] &&
		 st_r.prio_r[7:6] >= st_r.prio_r[3:2] &&
		 st_r.prio_r[7:6] >= st_r.prio_r[1:0]) |-> best[1:0] == 2'h0)
		else $error("tie not resolved toward lower index");

	AST_RANK_ORDER: assert property (
		(valid_w[3] && st_r.prio_r[1:0] == 2'h3 &&
		 st_r.prio_r[7:6] != 2'h3 && st_r.prio_r[5:4] != 2'h3 &&
		 st_r.prio_r[3:2] != 2'h3) |-> best == 3'h7)
		else $error("highest rank code did not win");

	AST_IGNORE_REVERT: assert property (
		(st_r.state == RSEL_ST_HOLDOFF && mode == RSEL_MODE_SHOLD &&
		 !st_r.override && !reg_wr_in &&
		 !(st_r.hold_run && !cur_ok && hold_tick &&
		   st_r.hold_cnt <= 8'h01 && best[2])) |=>
		    st_r.ref_r == $past(st_r.mode_r[1:0]))
		else $error("holdoff mode left the select field");

endmodule
`default_nettype wire

// file: testbench/rsel_top_test.sv
// testbench: register-level scenarios for the reference input selector
`timescale 1ns/1ps
`default_nettype none
module rsel_top_test
	import rsel_pkg::*;
;
	// ------------------------------------------------------------------
	// signals and design
	// ------------------------------------------------------------------
	logic       core_clk_in;
	logic       reset_n_in;
	logic       reg_wr_in;
	logic       reg_rd_in;
	logic [7:0] reg_addr_in;
	logic [7:0] reg_wdata_in;
	logic [7:0] reg_rdata_out;
	logic [3:0] in_period_edge_in;
	logic [3:0] in_period_miss_in;
	logic [3:0] signal_loss_in;
	logic       vcxo_tick_in;
	logic [1:0] ref_select_out;
	logic       holdover_out;
	logic [3:0] input_valid_out;
	logic       reference_loss_block_out;
	logic [1:0] input_power_down_out;
	int         fails;
	int         total_checks;

	// short holdoff divider keeps the failover run brief
	rsel_top #(
		.NUM_INPUTS       (4),
		.HOLDOFF_DIV_LOG2 (1)
	) dut (
		.core_clk_in              (core_clk_in),
		.reset_n_in               (reset_n_in),
		.reg_wr_in                (reg_wr_in),
		.reg_rd_in                (reg_rd_in),
		.reg_addr_in              (reg_addr_in),
		.reg_wdata_in             (reg_wdata_in),
		.reg_rdata_out            (reg_rdata_out),
		.in_period_edge_in        (in_period_edge_in),
		.in_period_miss_in        (in_period_miss_in),
		.signal_loss_in           (signal_loss_in),
		.vcxo_tick_in             (vcxo_tick_in),
		.ref_select_out           (ref_select_out),
		.holdover_out             (holdover_out),
		.input_valid_out          (input_valid_out),
		.reference_loss_block_out (reference_loss_block_out),
		.input_power_down_out     (input_power_down_out)
	);

	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end

	// ------------------------------------------------------------------
	// compare and access tasks
	// ------------------------------------------------------------------
	task automatic bad(input int got, input int exp);
		fails++;
		$display("BAD %0t got %0h expected %0h", $time, got, exp);
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) bad(got, exp);
	endtask

	task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
		total_checks++;
		if (got !== exp) bad(got, exp);
	endtask

	task automatic cmp2(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) bad(got, exp);
	endtask

	task automatic cmp1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) bad(got, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask

	// settle time covers state step plus reference step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_in  = a;
		reg_wdata_in = d;
		reg_wr_in    = 1'b1;
		cyc(1);
		reg_wr_in = 1'b0;
		cyc(3);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr_in = a;
		reg_rd_in   = 1'b1;
		cyc(1);
		reg_rd_in = 1'b0;
		cmp8(reg_rdata_out, exp);
	endtask

	task automatic lose(input logic [3:0] m);
		signal_loss_in = m;
		cyc(1);
		signal_loss_in = 4'h0;
		cyc(3);
	endtask

	task automatic edges(input logic [3:0] m, input int n);
		repeat (n) begin
			in_period_edge_in = m;
			cyc(1);
			in_period_edge_in = 4'h0;
			cyc(1);
		end
		cyc(3);
	endtask

	task automatic vcxo(input int n);
		repeat (n) begin
			vcxo_tick_in = 1'b1;
			cyc(1);
			vcxo_tick_in = 1'b0;
			cyc(1);
		end
		cyc(3);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// watchdog: tests need a few hundred cycles, allow far more
	// ------------------------------------------------------------------
	initial begin
		#100000;
		$display("BAD %0t watchdog expired", $time);
		fails++;
		final_report();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		fails             = 0;
		total_checks      = 0;
		reset_n_in        = 1'b0;
		reg_wr_in         = 1'b0;
		reg_rd_in         = 1'b0;
		reg_addr_in       = 8'h00;
		reg_wdata_in      = 8'h00;
		in_period_edge_in = 4'h0;
		in_period_miss_in = 4'h0;
		signal_loss_in    = 4'h0;
		vcxo_tick_in      = 1'b0;
		repeat (12) @(posedge core_clk_in);
		cyc(1);
		reset_n_in = 1'b1;
		cmp2(ref_select_out, 2'h0);
		cmp1(holdover_out, 1'b0);
		cmp4(input_valid_out, 4'h0);
		rd(RSEL_OFS_PRIO, 8'he4);
		rd(RSEL_OFS_MODE, 8'h00);
		rd(RSEL_OFS_HOLD, 8'h80);
		rd(RSEL_OFS_SETUP, 8'h82);
		rd(8'h20, 8'h00);
		// reserved bits masked, status read-only
		wr(RSEL_OFS_MODE, 8'hc0);
		rd(RSEL_OFS_MODE, 8'h40);
		cmp1(reference_loss_block_out, 1'b1);
		wr(RSEL_OFS_SETUP, 8'h3c);
		rd(RSEL_OFS_SETUP, 8'h0c);
		cmp2(input_power_down_out, 2'h3);
		wr(RSEL_OFS_STATUS, 8'hff);
		rd(RSEL_OFS_STATUS, 8'h00);
		wr(RSEL_OFS_MODE, 8'h00);
		wr(RSEL_OFS_SETUP, 8'h00);
		// manual select field
		wr(RSEL_OFS_MODE, 8'h01);
		cmp2(ref_select_out, 2'h1);
		wr(RSEL_OFS_MODE, 8'h00);
		cmp2(ref_select_out, 2'h0);
		// count of two, a missing edge restarts it
		lose(4'h1);
		edges(4'h1, 1);
		in_period_miss_in = 4'h1;
		cyc(1);
		in_period_miss_in = 4'h0;
		edges(4'h1, 1);
		cmp4(input_valid_out, 4'h0);
		edges(4'h1, 1);
		cmp4(input_valid_out, 4'h1);
		// prescale stretches the same count
		wr(RSEL_OFS_MODE, 8'h20);
		lose(4'h2);
		edges(4'h2, 7);
		cmp4(input_valid_out, 4'h1);
		edges(4'h2, 1);
		cmp4(input_valid_out, 4'h3);
		wr(RSEL_OFS_MODE, 8'h00);
		lose(4'hc);
		edges(4'hc, 2);
		cmp4(input_valid_out, 4'hf);
		// automatic failover by rank, ties by index
		wr(RSEL_OFS_PRIO, 8'h68);
		wr(RSEL_OFS_MODE, 8'h04);
		cmp2(ref_select_out, 2'h0);
		lose(4'h1);
		cmp2(ref_select_out, 2'h1);
		lose(4'h2);
		cmp2(ref_select_out, 2'h2);
		lose(4'h4);
		cmp2(ref_select_out, 2'h3);
		edges(4'h1, 2);
		cmp2(ref_select_out, 2'h3);
		// revertive: only a higher rank pulls the reference back
		wr(RSEL_OFS_MODE, 8'h14);
		lose(4'h1);
		edges(4'h1, 2);
		cmp2(ref_select_out, 2'h0);
		lose(4'h8);
		edges(4'h8, 2);
		cmp2(ref_select_out, 2'h0);
		wr(RSEL_OFS_MODE, 8'h11);
		cmp2(ref_select_out, 2'h1);
		lose(4'h1);
		edges(4'h1, 2);
		cmp2(ref_select_out, 2'h1);
		// no valid input: auto stays, auto holdover holds
		wr(RSEL_OFS_MODE, 8'h04);
		lose(4'hf);
		cmp2(ref_select_out, 2'h0);
		cmp1(holdover_out, 1'b0);
		edges(4'h2, 2);
		wr(RSEL_OFS_MODE, 8'h0c);
		lose(4'hf);
		cmp1(holdover_out, 1'b1);
		edges(4'h4, 2);
		cmp1(holdover_out, 1'b0);
		cmp2(ref_select_out, 2'h2);
		// short holdover: failover after three holdoff ticks
		edges(4'hb, 2);
		wr(RSEL_OFS_PRIO, 8'he4);
		wr(RSEL_OFS_HOLD, 8'h03);
		wr(RSEL_OFS_MODE, 8'h08);
		cmp2(ref_select_out, 2'h0);
		lose(4'h1);
		cmp1(holdover_out, 1'b1);
		vcxo(4);
		cmp2(ref_select_out, 2'h0);
		vcxo(2);
		cmp2(ref_select_out, 2'h1);
		cmp1(holdover_out, 1'b0);
		// equal top ranks on inputs 0 and 1: lower index wins
		wr(RSEL_OFS_PRIO, 8'hf0);
		wr(RSEL_OFS_MODE, 8'h0a);
		cmp2(ref_select_out, 2'h2);
		edges(4'h1, 2);
		lose(4'h4);
		vcxo(6);
		cmp2(ref_select_out, 2'h0);
		// a lone top rank on input 3 wins in auto mode
		wr(RSEL_OFS_PRIO, 8'h03);
		wr(RSEL_OFS_MODE, 8'h04);
		lose(4'h1);
		cmp2(ref_select_out, 2'h3);
		final_report();
	end
endmodule
`default_nettype wire
